/* hdl/acs_sequencer.sv */
/*
  Conversion sequencer of a 16-bit converter: power-down and reset
  handling, oscillator wake-up, fixed-rate conversion timing, result
  coding, data/ready pin and an Avalon-MM register slave.
  Assumes mclk at 10 MHz, sclk from the host (idle high, host samples
  on rising edges), and software supplying the input as a signed value.
*/
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
// Summary of operation
// - New result every 8 ms
// - First result only after 24 ms settling
// - Every conversion updates the result register
// - Power-down stops all, pin goes high-Z
// - Power-down resets all logic except the INPUT register, and serial state
// - Release waits 1 ms oscillator start, then samples
// - Pin driven high until first valid result
// - Power-on reset does the same, and clears the INPUT register too
// - Offset binary result coding
// - Code equals 2^15 times ratio plus one
// - 24-bit word: result then status byte
// - Status byte: ready, zero, error, ID, pattern
// - Pin falls when ready, rises once read
// - Unread result: pin rises before update
module acs_sequencer #(
  parameter int CONV_CYCLES = acs_pkg::CONV_CYC,
  parameter int SETTLE_CYCLES = acs_pkg::SETTLE_CYC,
  parameter int OSC_WAKE_CYCLES = acs_pkg::OSC_WAKE_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic power_down_reset_n,
  input wire logic sclk,
  output logic dout_rdy,
  output logic dout_rdy_en
);

  localparam acs_pkg::acs_cnt_type CONV_LAST =
    acs_pkg::acs_cnt_type'(CONV_CYCLES - 1);
  localparam acs_pkg::acs_cnt_type GUARD_AT =
    acs_pkg::acs_cnt_type'(CONV_CYCLES - 1 - acs_pkg::GUARD_CYC);
  localparam acs_pkg::acs_cnt_type WAKE_LAST =
    acs_pkg::acs_cnt_type'(OSC_WAKE_CYCLES - 1);
  localparam logic [15:0] SETTLE_N =
    16'(SETTLE_CYCLES / CONV_CYCLES);

  acs_pkg::acs_core_type state_reg;
  acs_pkg::acs_core_type state_next;

  logic ser_bit;
  logic ser_active;
  logic ser_done;
  logic srst_n;
  logic done_event;
  logic pd_active;
  logic signed [17:0] ain_s;
  logic range_err;
  logic signed [17:0] clamped;
  logic [15:0] code;
  acs_pkg::acs_word_type new_word;
  logic [31:0] wr_merged;
  logic [31:0] cur_input;
  logic [31:0] rd_value;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // Serial side, on the host's clock
  // ----------------------------------------------------------------
  // Either reset pin clears the shifter at once, with no clock needed
  assign srst_n = rst_n & power_down_reset_n;

  acs_serial_tx u_serial (
    .sclk(sclk),
    .srst_n(srst_n),
    .word(state_reg.word),
    .gen(state_reg.gen),
    .tx_bit(ser_bit),
    .tx_active(ser_active),
    .done_toggle(ser_done)
  );

  // ----------------------------------------------------------------
  // Result coding
  // ----------------------------------------------------------------
  assign ain_s = state_reg.ain;

  always_comb begin
    range_err = 1'b0;
    clamped = ain_s;
    if (ain_s > acs_pkg::IN_MAX) begin
      range_err = 1'b1;
      clamped = acs_pkg::IN_MAX;
    end else if (ain_s < acs_pkg::IN_MIN) begin
      range_err = 1'b1;
      clamped = acs_pkg::IN_MIN;
    end
  end

  // Adding mid-scale to a 16-bit two's complement value flips the sign bit
  assign code = clamped[15:0] ^ acs_pkg::CODE_MID;

  always_comb begin
    new_word.result = code;
    new_word.status.ready_n = 1'b1;
    new_word.status.zero = 1'b0;
    new_word.status.range_err = range_err;
    new_word.status.ident_bit_hi = acs_pkg::IDENT_CODE[1];
    new_word.status.ident_bit_lo = acs_pkg::IDENT_CODE[0];
    new_word.status.check_pattern_bit2 = acs_pkg::CHECK_PATTERN[2];
    new_word.status.check_pattern_bit1 = acs_pkg::CHECK_PATTERN[1];
    new_word.status.check_pattern_bit0 = acs_pkg::CHECK_PATTERN[0];
  end

  // ----------------------------------------------------------------
  // Register access helpers
  // ----------------------------------------------------------------
  // Upper bits of INPUT are not stored and always read as zero
  assign cur_input = {14'h0000, state_reg.ain};

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      // A lane without its enable keeps the stored bits
      assign wr_merged[lane*8 +: 8] = avs_byteenable[lane] ?
        avs_writedata[lane*8 +: 8] : cur_input[lane*8 +: 8];
    end
  endgenerate

  always_comb begin
    status_word = 32'h00000000;
    status_word[acs_pkg::STB_POWERED] = state_reg.oe;
    status_word[acs_pkg::STB_OSC_UP] =
      (state_reg.phase == acs_pkg::ACS_ST_CONV);
    status_word[acs_pkg::STB_SETTLED] = state_reg.settled;
    status_word[acs_pkg::STB_READY] = state_reg.oe & ~state_reg.rdy_pin;
    status_word[acs_pkg::STB_ERR] = state_reg.word.status.range_err;
  end

  always_comb begin
    case (avs_address)
      acs_pkg::OFS_INPUT: rd_value = cur_input;
      acs_pkg::OFS_STATUS: rd_value = status_word;
      acs_pkg::OFS_RESULT: rd_value = {8'h00, state_reg.word};
      acs_pkg::OFS_COUNT: rd_value = {16'h0000, state_reg.nconv};
      default: rd_value = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Clock-domain crossing
  // ----------------------------------------------------------------
  // The shifter flips a toggle at the end of a frame; a toggle survives
  // any ratio of the two clocks, where a pulse could be missed
  assign done_event = state_reg.done_sync[2] ^ state_reg.done_sync[1];
  // Only the second flop of the pin synchroniser is read, so a pin
  // edge near mclk cannot reach the state logic half-settled
  assign pd_active = ~state_reg.pd_sync[1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.pd_sync = {state_reg.pd_sync[0], power_down_reset_n};
    state_next.done_sync = {state_reg.done_sync[1:0], ser_done};

    // Bus slave: one wait cycle, then the answer
    state_next.ack = (avs_read | avs_write) & ~state_reg.ack;
    if (state_next.ack && avs_read) begin
      state_next.readdata = rd_value;
    end
    if (state_reg.ack && avs_write && avs_address == acs_pkg::OFS_INPUT)
    begin
      state_next.ain = wr_merged[17:0];
    end

    if (pd_active) begin
      // Powered down: everything idle and the pin released
      state_next.phase = acs_pkg::ACS_ST_OFF;
      state_next.cnt = '0;
      state_next.nconv = acs_pkg::COUNT_RST;
      state_next.gen = 1'b0;
      state_next.rdy_pin = 1'b1;
      state_next.oe = 1'b0;
      state_next.settled = 1'b0;
      state_next.word = {acs_pkg::RESULT_RST, 8'h00};
    end else begin
      case (state_reg.phase)
        acs_pkg::ACS_ST_OFF: begin
          state_next.oe = 1'b1;
          state_next.rdy_pin = 1'b1;
          state_next.cnt = '0;
          state_next.phase = acs_pkg::ACS_ST_WAKE;
        end
        acs_pkg::ACS_ST_WAKE: begin
          // Oscillator start-up before any sampling
          state_next.cnt = state_reg.cnt + 18'h00001;
          if (state_reg.cnt == WAKE_LAST) begin
            state_next.cnt = '0;
            state_next.phase = acs_pkg::ACS_ST_CONV;
          end
        end
        acs_pkg::ACS_ST_CONV: begin
          state_next.cnt = state_reg.cnt + 18'h00001;
          if (done_event) begin
            state_next.rdy_pin = 1'b1;
          end
          if (state_reg.cnt == GUARD_AT) begin
            // Result left unread: withdraw it before the update
            state_next.rdy_pin = 1'b1;
          end
          if (state_reg.cnt == CONV_LAST) begin
            state_next.cnt = '0;
            state_next.nconv = state_reg.nconv + 16'h0001;
            state_next.gen = ~state_reg.gen;
            state_next.word = new_word;
            if (state_reg.nconv + 16'h0001 >= SETTLE_N) begin
              state_next.settled = 1'b1;
            end
            if (state_next.settled) begin
              state_next.word.status.ready_n = 1'b0;
              state_next.rdy_pin = 1'b0;
            end
          end
        end
        default: begin
          state_next.phase = acs_pkg::ACS_ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.phase <= acs_pkg::ACS_ST_OFF;
      state_reg.rdy_pin <= 1'b1;
      state_reg.ain <= acs_pkg::INPUT_RST;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~state_reg.ack;
  assign avs_readdata = state_reg.readdata;

  // Pin shows the serial bit only during a read of the current result
  assign dout_rdy = state_reg.oe &
    (state_reg.rdy_pin | (ser_active & ser_bit));
  assign dout_rdy_en = state_reg.oe;

endmodule : acs_sequencer

/* common/acs_pkg.sv */
/*
  Shared constants and types of the conversion sequencer: timing counts,
  register offsets, field positions, reset values and the packed state
  records of both clock domains.
  Assumes a 10 MHz core clock and a 32-bit Avalon-MM register bus.
*/
package acs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CONV_PERIOD_US = 8000;
  localparam int SETTLE_US = 24000;
  localparam int OSC_WAKE_US = 1000;
  localparam int GUARD_NS = 2000;
  localparam int CONV_CYC = CONV_PERIOD_US * CYC_PER_US;
  localparam int SETTLE_CYC = SETTLE_US * CYC_PER_US;
  localparam int OSC_WAKE_CYC = OSC_WAKE_US * CYC_PER_US;
  localparam int GUARD_CYC = (GUARD_NS * CYC_PER_US + 999) / 1000;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_INPUT = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_RESULT = 4'h8;
  localparam logic [3:0] OFS_COUNT = 4'hC;
  localparam logic [17:0] INPUT_RST = 18'h00000;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam int STB_POWERED = 0;
  localparam int STB_OSC_UP = 1;
  localparam int STB_SETTLED = 2;
  localparam int STB_READY = 3;
  localparam int STB_ERR = 4;

  // ----------------------------------------------------------------
  // Result coding and serial word
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic signed [17:0] IN_MAX = 18'sh07FFF;
  localparam logic signed [17:0] IN_MIN = 18'sh38000;
  // Identification value is arbitrary
  localparam logic [1:0] IDENT_CODE = 2'h3;
  localparam logic [2:0] CHECK_PATTERN = 3'h5;
  localparam logic [4:0] SER_LAST = 5'h17;
  localparam logic [4:0] SER_BITS = 5'h18;

  typedef logic [17:0] acs_cnt_type;

  typedef enum logic [1:0] {
    ACS_ST_OFF,
    ACS_ST_WAKE,
    ACS_ST_CONV
  } acs_phase_type;

  typedef struct packed {
    logic ready_n;
    logic zero;
    logic range_err;
    logic ident_bit_hi;
    logic ident_bit_lo;
    logic check_pattern_bit2;
    logic check_pattern_bit1;
    logic check_pattern_bit0;
  } acs_status_type;

  typedef struct packed {
    logic [15:0] result;
    acs_status_type status;
  } acs_word_type;

  typedef struct packed {
    logic [1:0] pd_sync;
    logic [2:0] done_sync;
    acs_phase_type phase;
    acs_cnt_type cnt;
    logic [15:0] nconv;
    logic gen;
    logic rdy_pin;
    logic oe;
    logic settled;
    acs_word_type word;
    logic [17:0] ain;
    logic ack;
    logic [31:0] readdata;
  } acs_core_type;

  typedef struct packed {
    logic [4:0] cnt;
    logic tag;
    logic bit_q;
    logic done_tog;
  } acs_ser_type;

endpackage : acs_pkg

/* hdl/acs_serial_tx.sv */
/*
  Serial shifter of the conversion sequencer, clocked by the host's
  serial clock. Puts the 24-bit word out one bit per falling edge.
  Assumes the word and its generation bit stay still while the host
  reads, which the core guarantees by raising data/ready first.
*/
`timescale 1ns/1ns
module acs_serial_tx (
  input wire logic sclk,
  input wire logic srst_n,
  input wire acs_pkg::acs_word_type word,
  input wire logic gen,
  output logic tx_bit,
  output logic tx_active,
  output logic done_toggle
);

  acs_pkg::acs_ser_type state_reg;
  acs_pkg::acs_ser_type state_next;
  logic [23:0] flat;

  assign flat = word;

  // ----------------------------------------------------------------
  // Shift sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (state_reg.tag != gen) begin
      // New result: restart at the top bit
      state_next.tag = gen;
      state_next.cnt = 5'h01;
      state_next.bit_q = flat[acs_pkg::SER_LAST];
    end else if (state_reg.cnt != acs_pkg::SER_BITS) begin
      state_next.bit_q = flat[acs_pkg::SER_LAST - state_reg.cnt];
      state_next.cnt = state_reg.cnt + 5'h01;
      if (state_reg.cnt == acs_pkg::SER_LAST) begin
        state_next.done_tog = ~state_reg.done_tog;
      end
    end else begin
      state_next.bit_q = 1'b1;
    end
  end

  always_ff @(negedge sclk or negedge srst_n) begin
    if (!srst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tx_bit = state_reg.bit_q;
  assign tx_active = (state_reg.cnt != 5'h00) && (state_reg.tag == gen);
  assign done_toggle = state_reg.done_tog;

endmodule : acs_serial_tx

/* sim/acs_sequencer_chk.sv */
/* Port checker of the conversion sequencer.
   Bound to the top module; sees only its ports. */
`timescale 1ns/1ns
module acs_sequencer_chk #(
  parameter int CONV_CYCLES = acs_pkg::CONV_CYC,
  parameter int SETTLE_CYCLES = acs_pkg::SETTLE_CYC,
  parameter int OSC_WAKE_CYCLES = acs_pkg::OSC_WAKE_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic power_down_reset_n,
  input wire logic dout_rdy,
  input wire logic dout_rdy_en
);
  localparam int FIRST = OSC_WAKE_CYCLES + SETTLE_CYCLES;
  int up_cnt_reg;
  logic seen_low_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Cycles since the pin was enabled, and whether it was low since
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n || !dout_rdy_en) begin
      up_cnt_reg <= 0;
      seen_low_reg <= 1'b0;
    end else begin
      up_cnt_reg <= (up_cnt_reg < FIRST + 8) ? up_cnt_reg + 1 : up_cnt_reg;
      seen_low_reg <= seen_low_reg | !dout_rdy;
    end
  end
  bus_one_wait_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait not one cycle");
  pd_off_a: assert property (
    !power_down_reset_n [*4] |-> !dout_rdy_en) else $error("pin not off");
  off_quiet_a: assert property (
    !dout_rdy_en |-> !dout_rdy) else $error("pin value while off");
  wake_high_a: assert property (
    $rose(dout_rdy_en) |-> dout_rdy) else $error("pin not high on wake");
  wake_hold_a: assert property (
    $rose(power_down_reset_n) && !dout_rdy_en |-> !dout_rdy_en [*2])
    else $error("pin enabled too early");
  settle_high_a: assert property (
    dout_rdy_en && up_cnt_reg < FIRST - 3 |-> dout_rdy)
    else $error("ready before settling");
  first_ready_a: assert property (
    dout_rdy_en && up_cnt_reg == FIRST + 3 |-> seen_low_reg || !dout_rdy)
    else $error("first result late");
  reset_quiet_a: assert property (
    $rose(rst_n) |-> !dout_rdy_en) else $error("pin on at reset exit");
endmodule : acs_sequencer_chk

/* sim/acs_host_model.sv */
/* Host controller model: reads one 24-bit word over the serial link.
   Assumes start is raised only while a read is wanted. */
`timescale 1ns/1ns
module acs_host_model (
  input wire logic pin,
  input wire logic start,
  output logic sclk,
  output logic [23:0] word,
  output logic busy
);
  initial begin
    sclk = 1'b1;
    busy = 1'b0;
    word = 24'h0;
  end
  // Serial clock runs only inside a frame
  always @(posedge start) begin
    busy = 1'b1;
    wait (pin === 1'b0);
    #37;
    for (int i = 0; i < 24; i++) begin
      sclk = 1'b0;
      #62;
      sclk = 1'b1;
      word = {word[22:0], pin};
      #63;
    end
    busy = 1'b0;
  end
endmodule : acs_host_model

/* sim/test_acs_sequencer.sv */
/* Self-checking bench of the conversion sequencer.
   Assumes shortened timing counts and the host model. */
`timescale 1ns/1ns
module test_acs_sequencer;
  localparam int CONV = 100;
  localparam int FIRST = 350;
  localparam int G = acs_pkg::GUARD_CYC;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic pd_n = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, seen;
  logic avs_waitrequest, sclk, dout_rdy, dout_rdy_en, busy;
  logic start = 1'b0;
  logic pin_hold = 1'b0;
  logic [23:0] word;
  logic [31:0] q[$];
  logic signed [17:0] vals [5] = '{18'sh38000, 18'sh00000, 18'sh07FFF,
    18'sh09C40, 18'sh363C0};
  event got;
  int cyc = 0;
  int n_mismatch = 0;
  int num_checks = 0;
  wire pin = dout_rdy_en ? dout_rdy : ~pin_hold;

  always #50 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  always @(posedge mclk) pin_hold <= dout_rdy_en ? dout_rdy : pin_hold;

  acs_sequencer #(.CONV_CYCLES(CONV), .SETTLE_CYCLES(300),
    .OSC_WAKE_CYCLES(50)) i_dut (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .power_down_reset_n(pd_n),
    .sclk(sclk), .dout_rdy(dout_rdy), .dout_rdy_en(dout_rdy_en));
  acs_host_model i_host (.pin(pin), .start(start), .sclk(sclk),
    .word(word), .busy(busy));

  task automatic check(input logic [31:0] v, input logic [31:0] e);
    num_checks++;
    if (v !== e) begin
      n_mismatch++;
      $display("BAD %0t: seen %h expected %h", $time, v, e);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    seen = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
    -> got;
  endtask : rd

  task automatic hread(input logic [23:0] e);
    q.push_back({8'h0, e});
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    @(posedge mclk);
    wait (busy === 1'b0);
    seen = {8'h0, word};
    -> got;
  endtask : hread

  task automatic lvl(input logic l, output int t);
    for (int n = 0; n < 3000 && pin !== l; n++) @(posedge mclk);
    if (pin !== l) begin
      n_mismatch++;
      $display("BAD %0t: pin level not reached", $time);
    end
    t = cyc;
  endtask : lvl

  function automatic logic inwin(input int d, input int lo, input int hi);
    return d >= lo && d <= hi;
  endfunction : inwin

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [23:0] expw(input logic signed [17:0] v);
    logic err;
    logic [15:0] c;
    err = (v > acs_pkg::IN_MAX) || (v < acs_pkg::IN_MIN);
    c = 16'(v + 18'sh08000);
    if (err) c = v[17] ? 16'h0000 : 16'hFFFF;
    return {c, 2'h0, err, acs_pkg::IDENT_CODE, 3'h5};
  endfunction : expw

  initial forever begin
    @(got);
    check(seen, q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end

  initial begin
    logic signed [17:0] v;
    logic [15:0] s;
    logic [23:0] w;
    int t0, t1, t2, t3;
    s = 16'h2B95;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t0 = cyc;
    rd(acs_pkg::OFS_RESULT, 32'h0);
    rd(acs_pkg::OFS_COUNT, 32'h0);
    rd(4'h2, 32'h0);
    v = 18'sh07FFF;
    bus(1'b1, acs_pkg::OFS_INPUT, {14'h0, v});
    repeat (200) @(posedge mclk);
    rd(acs_pkg::OFS_STATUS, 32'h3);
    rd(acs_pkg::OFS_RESULT, {8'h0, expw(v)} | 32'h80);
    lvl(1'b0, t1);
    check(inwin(t1 - t0, FIRST, FIRST + 8), 1'b1);
    hread(expw(v));
    $display("done: reset and settling");
    for (int i = 0; i < 7; i++) begin
      s = lfsr(s);
      v = (i < 5) ? vals[i] : {{2{s[15]}}, s};
      w = expw(v);
      bus(1'b1, acs_pkg::OFS_INPUT, {14'h0, v});
      lvl(1'b1, t1);
      lvl(1'b0, t1);
      hread(w);
      repeat (4) @(posedge mclk);
      rd(acs_pkg::OFS_STATUS, {27'h0, w[5], 4'h7});
      lvl(1'b0, t2);
      check(t2 - t1, CONV);
      lvl(1'b1, t3);
      check(inwin(t3 - t2, CONV - 2 - G, CONV - G), 1'b1);
    end
    $display("done: coding, framing and rate");
    lvl(1'b0, t1);
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    repeat (8) @(posedge mclk);
    pd_n <= 1'b0;
    wait (busy === 1'b0);
    @(posedge mclk);
    rd(acs_pkg::OFS_COUNT, 32'h0);
    rd(acs_pkg::OFS_RESULT, 32'h0);
    pd_n <= 1'b1;
    t0 = cyc;
    lvl(1'b1, t2);
    lvl(1'b0, t1);
    check(inwin(t1 - t0, FIRST, FIRST + 8), 1'b1);
    hread(expw(v));
    $display("done: power-down in mid-read");
    close_out();
  end
endmodule : test_acs_sequencer

bind acs_sequencer acs_sequencer_chk #(.CONV_CYCLES(CONV_CYCLES),
  .SETTLE_CYCLES(SETTLE_CYCLES), .OSC_WAKE_CYCLES(OSC_WAKE_CYCLES))
  i_chk (.mclk(mclk), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .power_down_reset_n(power_down_reset_n), .dout_rdy(dout_rdy),
  .dout_rdy_en(dout_rdy_en));
